// ==== include/vgpio_pkg.sv ====
package vgpio_pkg;
  localparam int VGPIO_PINS = 23;
  localparam int VGPIO_DW = 32;
  localparam int VGPIO_AW = 8;
  // Register byte addresses
  localparam logic [7:0] VGPIO_OFS_OUT = 8'h00;
  localparam logic [7:0] VGPIO_OFS_SET = 8'h04;
  localparam logic [7:0] VGPIO_OFS_CLR = 8'h08;
  localparam logic [7:0] VGPIO_OFS_IEN = 8'h0C;
  localparam logic [7:0] VGPIO_OFS_POL = 8'h10;
  localparam logic [7:0] VGPIO_OFS_STAT = 8'h14;
  localparam logic [7:0] VGPIO_OFS_PCLR = 8'h18;
  localparam logic [7:0] VGPIO_OFS_FUNC = 8'h1C;
  localparam logic [7:0] VGPIO_OFS_DIR = 8'h20;
  localparam logic [7:0] VGPIO_OFS_MASK = 8'h24;
  localparam logic [7:0] VGPIO_OFS_ISTAT = 8'h28;
  // Field positions
  localparam int VGPIO_CTL3_BIT = 22;
  localparam int VGPIO_CTL2_BIT = 21;
  localparam int VGPIO_CTL1_BIT = 20;
  localparam int VGPIO_EVT_GPIO = 0;
  localparam int VGPIO_EVT_W = 1;
  localparam logic [22:0] VGPIO_PIN_RST = 23'h00_0000;
  localparam logic [31:0] VGPIO_ZERO = 32'h0000_0000;
endpackage

// ==== rtl/vgpio_edge.sv ====
`timescale 1ns/10ps
module vgpio_edge
  import vgpio_pkg::*;
#(
  parameter int WIDTH = VGPIO_PINS
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] polarity,
  output logic [WIDTH-1:0] edge_seen
);
  logic [WIDTH-1:0] sync1;
  logic [WIDTH-1:0] sync2;
  logic [WIDTH-1:0] prev;

  // Two stages against metastability, third holds the last sample
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end
    else
    begin
      sync1 <= pin_in;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_edge
      // Zero picks rising, one picks falling
      assign edge_seen[i] = polarity[i] ? (prev[i] & ~sync2[i]) : (~prev[i] & sync2[i]);
    end
  endgenerate
endmodule // vgpio_edge

// ==== rtl/vgpio_port.sv ====
`timescale 1ns/10ps
// Behaviour
// - Writing one to a clear-alias bit drives that output data bit low.
// - Writing zero to a clear-alias bit leaves that output bit alone.
// - Clear alias always reads back as zero.
// - Bits 22..20 are control pins three..one, bits 19..0 video data pins.
// - Clear touches only the selected output bits; other pins keep levels.
// - Bits 31..23 read zero and ignore writes in both registers.
// - Interrupt enable holds one read/write bit per pin, reset zero.
// - Pending bit sets only while the pin's enable bit is one.
// - Pin interrupt-capable only if enabled, general-purpose and input.
// - Pin events go out as processor interrupt and DMA event.
// - Polarity zero picks rising edge, polarity one picks falling edge.
// - Pending bits clear only by writing one to pending-clear register.
// - Output data drives a pin only when it is a general-purpose output.
module vgpio_port
  import vgpio_pkg::*;
#(
  parameter int PINS = VGPIO_PINS
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [VGPIO_AW-1:0] addr,
  input wire logic [VGPIO_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [VGPIO_DW-1:0] rdata,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe_n,
  output logic irq,
  output logic dma_event
);
  logic [PINS-1:0] pin_output_data;
  logic [PINS-1:0] pin_irq_enable;
  logic [PINS-1:0] edge_polarity;
  logic [PINS-1:0] pin_pending_status;
  logic [PINS-1:0] pin_function_select;
  logic [PINS-1:0] pin_direction;
  logic [VGPIO_EVT_W-1:0] irq_mask;
  logic [VGPIO_EVT_W-1:0] port_irq_status;
  logic [PINS-1:0] edge_seen;
  logic [PINS-1:0] capable;
  logic [PINS-1:0] wbits;
  logic [PINS-1:0] next_pending;
  logic [VGPIO_DW-1:0] next_rdata;
  logic any_set;
  logic [PINS-1:0] new_event;
  logic [PINS-1:0] drive_en;
  logic wr_out;
  logic wr_set;
  logic wr_clr;
  logic wr_ien;
  logic wr_pol;
  logic wr_pclr;
  logic wr_func;
  logic wr_dir;
  logic wr_mask;
  logic wr_istat;
  logic next_port_flag;
  logic next_irq;
  logic next_dma;

  assign wbits = wdata[PINS-1:0];

  // One strobe per writable address; unmapped addresses hit none
  assign wr_out = wr && (addr == VGPIO_OFS_OUT);
  assign wr_set = wr && (addr == VGPIO_OFS_SET);
  assign wr_clr = wr && (addr == VGPIO_OFS_CLR);
  assign wr_ien = wr && (addr == VGPIO_OFS_IEN);
  assign wr_pol = wr && (addr == VGPIO_OFS_POL);
  assign wr_pclr = wr && (addr == VGPIO_OFS_PCLR);
  assign wr_func = wr && (addr == VGPIO_OFS_FUNC);
  assign wr_dir = wr && (addr == VGPIO_OFS_DIR);
  assign wr_mask = wr && (addr == VGPIO_OFS_MASK);
  assign wr_istat = wr && (addr == VGPIO_OFS_ISTAT);

  vgpio_edge #(
    .WIDTH(PINS)
  ) u_edge (
    .clk(clk),
    .resetn(resetn),
    .pin_in(pin_in),
    .polarity(edge_polarity),
    .edge_seen(edge_seen)
  );

  // Per-pin qualification, output data and pending capture
  genvar n;
  generate
    for (n = 0; n < PINS; n++)
    begin : g_pin
      // Direction one means input
      assign capable[n] = pin_irq_enable[n] & pin_function_select[n] & pin_direction[n];
      assign new_event[n] = edge_seen[n] & capable[n];
      // Only general-purpose outputs are driven
      assign drive_en[n] = pin_function_select[n] & ~pin_direction[n];

      // Each output bit follows its own strobes; a zero bit holds it on set or clear writes, but a zero written to the output register clears it
      always_ff @(posedge clk)
      begin
        if (!resetn)
        begin
          pin_output_data[n] <= VGPIO_PIN_RST[n];
        end
        else if (wr_out)
        begin
          pin_output_data[n] <= wbits[n];
        end
        else if (wr_set && wbits[n])
        begin
          pin_output_data[n] <= 1'b1;
        end
        else if (wr_clr && wbits[n])
        begin
          pin_output_data[n] <= 1'b0;
        end
      end

      // A new edge wins over a clear in the same cycle, so no event is lost
      assign next_pending[n] = new_event[n]
        | (pin_pending_status[n] & ~(wr_pclr & wbits[n]));

      always_ff @(posedge clk)
      begin
        if (!resetn)
        begin
          pin_pending_status[n] <= VGPIO_PIN_RST[n];
        end
        else
        begin
          pin_pending_status[n] <= next_pending[n];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pin_irq_enable <= VGPIO_PIN_RST;
    end
    else if (wr_ien)
    begin
      pin_irq_enable <= wbits;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      edge_polarity <= VGPIO_PIN_RST;
    end
    else if (wr_pol)
    begin
      edge_polarity <= wbits;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pin_function_select <= VGPIO_PIN_RST;
    end
    else if (wr_func)
    begin
      pin_function_select <= wbits;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pin_direction <= VGPIO_PIN_RST;
    end
    else if (wr_dir)
    begin
      pin_direction <= wbits;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      irq_mask <= '0;
    end
    else if (wr_mask)
    begin
      irq_mask <= wdata[VGPIO_EVT_W-1:0];
    end
  end

  assign any_set = |pin_pending_status;

  // Port flag re-asserts while any pending bit stays set
  always_comb
  begin
    next_port_flag = port_irq_status[VGPIO_EVT_GPIO];
    if (wr_istat && wdata[VGPIO_EVT_GPIO])
      next_port_flag = 1'b0;
    if (any_set)
      next_port_flag = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      port_irq_status <= '0;
    end
    else
    begin
      port_irq_status[VGPIO_EVT_GPIO] <= next_port_flag;
    end
  end

  // Registered outputs cost one cycle but never glitch
  assign next_irq = |(port_irq_status & irq_mask);
  assign next_dma = |new_event;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= next_irq;
    end
  end

  // One-cycle DMA trigger for each cycle with a newly captured event
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      dma_event <= 1'b0;
    end
    else
    begin
      dma_event <= next_dma;
    end
  end

  // Drive only general-purpose outputs; enable is active low
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pin_out <= VGPIO_PIN_RST;
    end
    else
    begin
      pin_out <= pin_output_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pin_oe_n <= ~VGPIO_PIN_RST;
    end
    else
    begin
      pin_oe_n <= ~drive_en;
    end
  end

  always_comb
  begin
    next_rdata = VGPIO_ZERO;
    case (addr)
      VGPIO_OFS_OUT: next_rdata[PINS-1:0] = pin_output_data;
      VGPIO_OFS_IEN: next_rdata[PINS-1:0] = pin_irq_enable;
      VGPIO_OFS_POL: next_rdata[PINS-1:0] = edge_polarity;
      VGPIO_OFS_STAT: next_rdata[PINS-1:0] = pin_pending_status;
      VGPIO_OFS_FUNC: next_rdata[PINS-1:0] = pin_function_select;
      VGPIO_OFS_DIR: next_rdata[PINS-1:0] = pin_direction;
      VGPIO_OFS_MASK: next_rdata[VGPIO_EVT_W-1:0] = irq_mask;
      VGPIO_OFS_ISTAT: next_rdata[VGPIO_EVT_W-1:0] = port_irq_status;
      VGPIO_OFS_SET: next_rdata = VGPIO_ZERO;
      VGPIO_OFS_CLR: next_rdata = VGPIO_ZERO;
      VGPIO_OFS_PCLR: next_rdata = VGPIO_ZERO;
      default: next_rdata = VGPIO_ZERO;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rdata <= VGPIO_ZERO;
    end
    else if (rd)
    begin
      rdata <= next_rdata;
    end
    else
    begin
      rdata <= VGPIO_ZERO;
    end
  end
endmodule // vgpio_port

// ==== testbench/vgpio_port_sva.sv ====
`timescale 1ns/10ps
module vgpio_port_sva
  import vgpio_pkg::*;
#(
  parameter int PINS = VGPIO_PINS
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [VGPIO_AW-1:0] addr,
  input wire logic [VGPIO_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [VGPIO_DW-1:0] rdata,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe_n,
  input wire logic irq,
  input wire logic dma_event
);
  logic [2:0] quiet;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Saturates so a quiet port never wraps back into the window
  always_ff @(posedge clk)
    if (!resetn)
      quiet <= 3'h7;
    else
      quiet <= (pin_in != $past(pin_in)) ? 3'h0 : quiet + 3'(quiet != 3'h7);
  AST_CLR_ONE: assert property (wr && addr == VGPIO_OFS_CLR |-> ##2
    (pin_out & $past(wdata[PINS-1:0], 2)) == '0) else $error("clear left bit");
  AST_CLR_ZERO: assert property (wr && addr == VGPIO_OFS_CLR |-> ##2
    ((pin_out ^ $past(pin_out)) & ~$past(wdata[PINS-1:0], 2)) == '0) else $error("bit moved");
  AST_CLR_READ: assert property (rd && addr == VGPIO_OFS_CLR |=> rdata == '0)
    else $error("clear alias read");
  AST_RSV_READ: assert property (rd |=> rdata[31:23] == 9'h000)
    else $error("reserved bits set");
  AST_IEN_RW: assert property (wr && addr == VGPIO_OFS_IEN ##2 rd && addr == VGPIO_OFS_IEN
    |=> rdata == {9'h000, $past(wdata[PINS-1:0], 3)}) else $error("enable readback");
  AST_EDGE_CAUSE: assert property (dma_event |-> quiet < 3'h6)
    else $error("event without edge");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(dma_event, 2) || $past(wr)
    || $past(wr, 2)) else $error("irq without cause");
  AST_PIN_CAUSE: assert property (!$stable({pin_out, pin_oe_n}) |-> $past(wr, 2))
    else $error("pin moved alone");
  cover property (dma_event);
  cover property ($rose(irq));
  cover property (wr && addr == VGPIO_OFS_CLR);
endmodule // vgpio_port_sva
bind vgpio_port vgpio_port_sva #(.PINS(PINS)) u_vgpio_port_sva (.clk, .resetn, .addr, .wdata,
  .wr, .rd, .rdata, .pin_in, .pin_out, .pin_oe_n, .irq, .dma_event);

// ==== testbench/vgpio_pins_model.sv ====
`timescale 1ns/10ps
module vgpio_pins_model
  import vgpio_pkg::*;
(
  input wire logic [VGPIO_PINS-1:0] pin_out,
  input wire logic [VGPIO_PINS-1:0] pin_oe_n,
  input wire logic [VGPIO_PINS-1:0] drive,
  output logic [VGPIO_PINS-1:0] pin_in
);
  // Outside source owns the line only while the port releases it
  assign pin_in = (pin_out & ~pin_oe_n) | (drive & pin_oe_n);
endmodule // vgpio_pins_model

// ==== testbench/vgpio_port_tb.sv ====
`timescale 1ns/10ps
module vgpio_port_tb
  import vgpio_pkg::*;
;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, irq, dma_event;
  logic [7:0] addr = '0;
  logic [31:0] wdata = '0, rdata, o, c, q[$];
  logic [22:0] pin_in, pin_out, pin_oe_n, drv = '0;
  int num_errors = 0, samples_checked = 0, seed = 13, cyc = 0, evts = 0;
  always #50 clk = ~clk;
  vgpio_port u_vgpio_port (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .irq(irq), .dma_event(dma_event));
  vgpio_pins_model u_vgpio_pins_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .drive(drv),
    .pin_in(pin_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, want);
    end
  endtask
  // A read carries its expected word into the queue
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    if (!w)
      q.push_back(d);
    @(posedge clk);
    wr <= 0;
    rd <= 0;
  endtask
  // Leaves room for the two-stage synchroniser and the status chain
  task automatic drive(input logic [22:0] v);
    drv <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic complete_run();
    if (num_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk)
    if (rd)
    begin
      @(negedge clk);
      check(rdata, q.pop_front());
    end
  // Counts DMA pulses mid-cycle, where the output has settled
  always @(negedge clk)
    if (dma_event === 1'b1)
      evts++;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 3000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    resetn <= 1;
    bus(0, VGPIO_OFS_IEN, 32'h0000_0000);
    bus(0, 8'h3C, 32'h0000_0000);
    bus(1, VGPIO_OFS_FUNC, 32'hFFFF_FFFF);
    bus(1, VGPIO_OFS_DIR, 32'h0040_0001);
    repeat (4)
    begin
      o = $random(seed);
      c = $random(seed);
      bus(1, VGPIO_OFS_OUT, o);
      bus(1, VGPIO_OFS_CLR, c);
      bus(0, VGPIO_OFS_OUT, o & ~c & 32'h007F_FFFF);
      bus(0, VGPIO_OFS_CLR, 32'h0000_0000);
      @(negedge clk);
      check(pin_out, o & ~c & 32'h007F_FFFF);
      check(pin_oe_n, 32'h0040_0001);
      bus(1, VGPIO_OFS_IEN, c);
      bus(0, VGPIO_OFS_IEN, c & 32'h007F_FFFF);
    end
    // Input pins 0 and 22 driven from outside with only pin 0 enabled, rising then falling polarity
    bus(0, VGPIO_OFS_STAT, 32'h0000_0000);
    bus(1, VGPIO_OFS_IEN, 32'h0000_0001);
    for (int p = 0; p < 2; p++)
    begin
      bus(1, VGPIO_OFS_MASK, 32'(!p));
      bus(1, VGPIO_OFS_POL, 32'(p));
      drive(23'h40_0001);
      bus(0, VGPIO_OFS_STAT, 32'(!p));
      check(evts, 32'h0000_0001);
      drive(23'h00_0000);
      bus(0, VGPIO_OFS_STAT, 32'h0000_0001);
      check(evts, 32'(1 + p));
      @(negedge clk);
      check(irq, 32'(!p));
      bus(1, VGPIO_OFS_PCLR, 32'h0000_0000);
      bus(0, VGPIO_OFS_STAT, 32'h0000_0001);
      bus(1, VGPIO_OFS_PCLR, 32'h0000_0001);
      bus(1, VGPIO_OFS_ISTAT, 32'h0000_0001);
      bus(0, VGPIO_OFS_STAT, 32'h0000_0000);
      @(negedge clk);
      check(irq, 32'h0000_0000);
    end
    // Enabled input pin that is not general-purpose must stay silent
    bus(1, VGPIO_OFS_POL, 32'h0000_0000);
    bus(1, VGPIO_OFS_FUNC, 32'h007F_FFFE);
    drive(23'h00_0001);
    bus(0, VGPIO_OFS_STAT, 32'h0000_0000);
    check(evts, 32'h0000_0002);
    repeat (2) @(posedge clk);
    complete_run();
  end
endmodule // vgpio_port_tb
